// >>> core/pin_sync.sv
// Three-flop pin synchroniser that accepts a level once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Raw pins and filtered levels.
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] ff1_r;
    logic [W-1:0] ff2_r;
    logic [W-1:0] ff3_r;
    logic [W-1:0] level_r;

    // Shift chain; the held level follows only where stages two and three agree.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ff1_r   <= '0;
            ff2_r   <= '0;
            ff3_r   <= '0;
            level_r <= '0;
        end else begin
            ff1_r   <= pin_in;
            ff2_r   <= ff1_r;
            ff3_r   <= ff2_r;
            level_r <= (ff2_r & ff3_r) | (level_r & (ff2_r | ff3_r));
        end
    end

    assign level_out = level_r;

    chk_sync_agree: assert property (@(posedge aclk) disable iff (!aresetn)
        level_r != $past(level_r) |-> ($past(ff2_r) ^ $past(ff3_r)) == '0)
        else $error("Synced level changed while stages disagreed.");
endmodule : pin_sync
`default_nettype wire

// >>> core/seq_map.svh
// Constants for the microstep sequencer: offsets, fields, resets and timing.
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
`define SEQ_CLK_NS   8
`define SEQ_CLK_HZ   125000000
`define SER_BAUD_MIN 9600
`define SER_BIT_MIN  16'h0010
`define SER_SYNC     8'h05
`define SER_LAST_BIT 3'h7
`define STILL_US     20000
`define INTERP_NS    64
`define REG_CTRL     12'h000
`define REG_VEL      12'h004
`define REG_STAT     12'h008
`define REG_COIL     12'h00C
`define CTRL_RST     32'h0000_0010
`define B_DUAL       0
`define B_PINDIS     1
`define B_EN         2
`define B_RED        3
`define B_INTP       4
`define F_MRES       11:8
`define MRES_FULL    4'h8
`define RES_PIN_00   4'h5
`define RES_PIN_01   4'h3
`define RES_PIN_10   4'h2
`define RES_PIN_11   4'h4
`define VEL_SIGN     23
`define AXI_OKAY     2'h0
`define AXI_SLVERR   2'h2
`endif

// >>> core/seq_pkg.sv
// Types shared by the microstep sequencer files.
package seq_pkg;
    typedef enum logic [1:0] {SER_IDLE, SER_MEAS, SER_BITS, SER_GAP} ser_state_t;
    typedef logic [9:0] mstep_t;
    typedef logic signed [8:0] coil_t;
endpackage : seq_pkg

// >>> core/sine_lut.sv
// Sine and cosine coil targets from the microstep counter.
`timescale 1ns/1ps
`default_nettype none
module sine_lut
    import seq_pkg::*;
(
    // Microstep position in.
    input  wire logic [9:0] phase,
    // Signed coil targets out.
    output coil_t           sine_val,
    output coil_t           cos_val
);
    localparam logic [8:0] TBL [17] = '{9'h000, 9'h019, 9'h032, 9'h04A, 9'h062, 9'h079,
        9'h08E, 9'h0A2, 9'h0B4, 9'h0C5, 9'h0D4, 9'h0E1, 9'h0EC, 9'h0F4, 9'h0FA,
        9'h0FE, 9'h0FF};

    // Quarter-wave table with linear interpolation between sixteen-step knots.
    function automatic coil_t sin_of(input mstep_t p);
        logic [8:0]  x;
        logic [4:0]  k;
        logic [8:0]  lo;
        logic [8:0]  hi;
        logic [12:0] d;
        logic [8:0]  mag;
        x   = p[8] ? 9'(9'h100 - {1'b0, p[7:0]}) : {1'b0, p[7:0]};
        k   = x[8:4];
        lo  = TBL[k];
        hi  = (k == 5'h10) ? TBL[k] : TBL[5'(k + 5'h01)];
        d   = 13'((hi - lo) * x[3:0]);
        mag = 9'(lo + d[12:4]);
        return p[9] ? coil_t'(9'(-mag)) : coil_t'(mag);
    endfunction : sin_of

    // The cosine leads the sine by one fullstep.
    assign sine_val = sin_of(phase);
    assign cos_val  = sin_of(10'(phase + 10'h100));
endmodule : sine_lut
`default_nettype wire

// >>> core/step_dir_microstep_sequencer.sv
// Step/direction microstep sequencer with serial detect and AXI4-Lite registers.
// Function
// - Advance on rising step edges, or both edges in dual-edge mode.
// - Sample direction at each active step edge to choose the way.
// - Direction low counts up, high counts down, by resolution-sized increments.
// - Support fullstep and 2 to 256 microsteps per fullstep.
// - Map microstep counter through sine/cosine table to coil targets.
// - Pins alone select 8, 16, 32 or 64 microsteps.
// - Interpolate coarse steps to 256-microstep smoothness.
// - Serial interface activates itself on the first well-formed frame carrying the pin-selected address.
// - Control bits can override pin settings in serial mode.
// - Detect master bit rate automatically, 9600 to 500k baud at least.
// - Respond to one of four bus addresses.
// - Internal step generator moves at a programmed velocity.
// - Internal generator takes direction from the velocity sign.
// - External step/dir and internal generator can alternate.
// - Active-low enable pin switches motor drive on and off.
// - Power-down pin level selects standstill current reduction until serial mode, then a control bit does.
// - Resolution pins 00=1/8, 01=1/32, 10=1/64, 11=1/16; address in serial.
// - Index pulses once per four fullsteps at counter zero.
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.svh"
module step_dir_microstep_sequencer
    import seq_pkg::*;
#(
    parameter int BIT_TIMEOUT = 2 * `SEQ_CLK_HZ / `SER_BAUD_MIN,
    parameter int STILL_CYC   = `STILL_US * 1000 / `SEQ_CLK_NS
) (
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels.
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels.
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Device pins.
    input  wire logic        step_pin,
    input  wire logic        dir_pin,
    input  wire logic        driver_enable_n,
    input  wire logic        powerdown_serial_pin,
    input  wire logic        resolution_select_0,
    input  wire logic        resolution_select_1,
    // Motor-side status and targets.
    output coil_t            coil_a,
    output coil_t            coil_b,
    output logic             drive_on,
    output logic             standstill_reduce,
    output logic             index_pulse,
    output logic             serial_active
);
    localparam int INTERP_CYC = (`INTERP_NS + `SEQ_CLK_NS - 1) / `SEQ_CLK_NS;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [5:0]  sync_v;
    logic        step_s, dir_s, enn_s, ser_s, ms0_s, ms1_s;
    logic        drv_en_s, ser_low_s;
    logic        step_prev_r, ser_prev_r;
    logic [31:0] ctrl_r;
    logic [23:0] vel_r;
    logic [23:0] acc_r;
    logic [23:0] vabs;
    logic        gen_on, gen_step, ext_edge, step_ev, step_back, use_pins;
    logic [3:0]  shift_eff;
    mstep_t      incr, target_r, mstep_r;
    logic [7:0]  div_r;
    logic [21:0] still_r;
    logic        still_r_hit, reduce_en;
    coil_t       sin_w, cos_w;

    // Filter every asynchronous pin through the three-stage synchroniser.
    pin_sync #(.W(6)) u_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin_in    ({step_pin, dir_pin, !driver_enable_n, !powerdown_serial_pin,
                     resolution_select_1, resolution_select_0}),
        .level_out (sync_v)
    );
    // Enable and serial line pass inverted, so a cleared chain reads as drive off and line idle.
    assign {step_s, dir_s, drv_en_s, ser_low_s, ms1_s, ms0_s} = sync_v;
    assign enn_s = !drv_en_s;
    assign ser_s = !ser_low_s;

    // Decode the two resolution pins into a step shift.
    function automatic logic [3:0] pin_shift(input logic [1:0] ms);
        case (ms)
            2'h0:    return `RES_PIN_00;
            2'h1:    return `RES_PIN_01;
            2'h2:    return `RES_PIN_10;
            default: return `RES_PIN_11;
        endcase
    endfunction : pin_shift

    // Byte-lane merge for register writes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Scale a coil target to about nine sixteenths at standstill.
    function automatic coil_t coil_scale(input coil_t v, input logic red);
        return red ? coil_t'((v >>> 1) + (v >>> 4)) : v;
    endfunction : coil_scale

    // Serial frame detector: start-bit timing gives the bit length.
    ser_state_t  ser_st_r;
    logic [15:0] cnt_r, bitlen_r;
    logic [2:0]  bit_i_r;
    logic        byte1_r, skip_r, serial_r;
    logic [7:0]  shreg_r, sh_nxt;
    assign sh_nxt = {ser_s, shreg_r[7:1]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ser_st_r <= SER_IDLE;
            cnt_r    <= 16'h0000;
            bitlen_r <= 16'h0000;
            bit_i_r  <= 3'h0;
            byte1_r  <= 1'b0;
            skip_r   <= 1'b0;
            shreg_r  <= 8'h00;
            serial_r <= 1'b0;
        end else begin
            cnt_r <= 16'(cnt_r + 16'h0001);
            case (ser_st_r)
                SER_IDLE: begin
                    cnt_r <= 16'h0000;
                    if (ser_prev_r && !ser_s) begin
                        ser_st_r <= SER_MEAS;
                    end
                end
                SER_MEAS: begin
                    if (ser_s) begin
                        bitlen_r <= cnt_r;
                        cnt_r    <= 16'h0000;
                        bit_i_r  <= 3'h0;
                        byte1_r  <= 1'b0;
                        skip_r   <= 1'b0;
                        ser_st_r <= (cnt_r >= `SER_BIT_MIN) ? SER_BITS : SER_IDLE;
                    end else if (cnt_r == 16'(BIT_TIMEOUT)) begin
                        ser_st_r <= SER_IDLE;
                    end
                end
                SER_BITS: begin
                    if (cnt_r == (bitlen_r >> 1) && !skip_r) begin
                        shreg_r <= sh_nxt;
                        if (bit_i_r == `SER_LAST_BIT) begin
                            ser_st_r <= SER_IDLE;
                            if (!byte1_r && sh_nxt == `SER_SYNC) begin
                                ser_st_r <= SER_GAP;
                                cnt_r    <= 16'h0000;
                            end
                            if (byte1_r && sh_nxt[1:0] == {ms1_s, ms0_s}) begin
                                serial_r <= 1'b1;
                            end
                        end
                    end
                    if (cnt_r == 16'(bitlen_r - 16'h0001)) begin
                        cnt_r   <= 16'h0000;
                        skip_r  <= 1'b0;
                        bit_i_r <= skip_r ? bit_i_r : 3'(bit_i_r + 3'h1);
                    end
                end
                SER_GAP: begin
                    if (ser_prev_r && !ser_s) begin
                        ser_st_r <= SER_BITS;
                        cnt_r    <= 16'h0000;
                        bit_i_r  <= 3'h0;
                        byte1_r  <= 1'b1;
                        skip_r   <= 1'b1;
                    end else if (cnt_r == 16'(BIT_TIMEOUT)) begin
                        ser_st_r <= SER_IDLE;
                    end
                end
                default: ser_st_r <= SER_IDLE;
            endcase
        end
    end
    assign serial_active = serial_r;

    // Resolution and option source: pins unless serial mode hands control to registers.
    assign use_pins  = !(serial_r && ctrl_r[`B_PINDIS]);
    assign shift_eff = use_pins ? pin_shift({ms1_s, ms0_s}) :
                       ((ctrl_r[`F_MRES] > `MRES_FULL) ? `MRES_FULL : ctrl_r[`F_MRES]);
    assign incr      = mstep_t'(10'h001 << shift_eff);

    // Internal generator: phase accumulator on the velocity magnitude.
    assign gen_on = (vel_r != 24'h00_0000);
    assign vabs   = vel_r[`VEL_SIGN] ? 24'(-vel_r) : vel_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_r    <= 24'h00_0000;
            gen_step <= 1'b0;
        end else begin
            {gen_step, acc_r} <= gen_on ? 25'({1'b0, acc_r} + {1'b0, vabs}) : 25'h000_0000;
        end
    end

    // Edge selection and step event merge.
    assign ext_edge  = ctrl_r[`B_DUAL] ? (step_s != step_prev_r) : (step_s && !step_prev_r);
    assign step_ev   = gen_on ? gen_step : ext_edge;
    assign step_back = gen_on ? vel_r[`VEL_SIGN] : dir_s;

    // Commanded position wraps naturally at one electrical period.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_prev_r <= 1'b0;
            ser_prev_r  <= 1'b1;
            target_r    <= 10'h000;
        end else begin
            step_prev_r <= step_s;
            ser_prev_r  <= ser_s;
            if (step_ev) begin
                target_r <= step_back ? 10'(target_r - incr) : 10'(target_r + incr);
            end
        end
    end

    // Interpolator walks the output position one microstep at a time.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mstep_r     <= 10'h000;
            div_r       <= 8'h00;
            index_pulse <= 1'b0;
        end else begin
            index_pulse <= 1'b0;
            div_r       <= (div_r == 8'(INTERP_CYC - 1)) ? 8'h00 : 8'(div_r + 8'h01);
            if (!ctrl_r[`B_INTP]) begin
                mstep_r     <= target_r;
                index_pulse <= (target_r == 10'h000) && (mstep_r != 10'h000);
            end else if (div_r == 8'h00 && mstep_r != target_r) begin
                mstep_r <= 10'(target_r - mstep_r) >= 10'h200 ? 10'(mstep_r - 10'h001)
                                                              : 10'(mstep_r + 10'h001);
                index_pulse <= (10'(target_r - mstep_r) >= 10'h200) ? (mstep_r == 10'h001)
                                                                    : (mstep_r == 10'h3FF);
            end
        end
    end

    // Standstill timer and current reduction select.
    assign still_r_hit = (still_r == 22'(STILL_CYC));
    assign reduce_en   = serial_r ? ctrl_r[`B_RED] : !ser_s;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            still_r <= 22'h00_0000;
        end else if (step_ev) begin
            still_r <= 22'h00_0000;
        end else if (!still_r_hit) begin
            still_r <= 22'(still_r + 22'h00_0001);
        end
    end

    sine_lut u_lut (
        .phase    (mstep_r),
        .sine_val (sin_w),
        .cos_val  (cos_w)
    );

    // Registered coil targets, zero while the drive is off.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_on          <= 1'b0;
            standstill_reduce <= 1'b0;
            coil_a            <= '0;
            coil_b            <= '0;
        end else begin
            drive_on          <= !enn_s && (use_pins || ctrl_r[`B_EN]);
            standstill_reduce <= reduce_en && still_r_hit;
            coil_a <= drive_on ? coil_scale(sin_w, standstill_reduce) : coil_t'(9'h000);
            coil_b <= drive_on ? coil_scale(cos_w, standstill_reduce) : coil_t'(9'h000);
        end
    end

    // AXI4-Lite write path: address and data taken in either order.
    logic        aw_have_r, w_have_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    assign awready = !aw_have_r && !bvalid;
    assign wready  = !w_have_r && !bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= 12'h000;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `AXI_OKAY;
            ctrl_r    <= `CTRL_RST;
            vel_r     <= 24'h00_0000;
        end else begin
            if (awvalid && awready) begin
                aw_have_r <= 1'b1;
                awaddr_r  <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_r <= 1'b1;
                wdata_r  <= wdata;
                wstrb_r  <= wstrb;
            end
            if (aw_have_r && w_have_r && !bvalid) begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= `AXI_OKAY;
                case (awaddr_r)
                    `REG_CTRL: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
                    `REG_VEL:  vel_r  <= 24'(merge({8'h00, vel_r}, wdata_r, wstrb_r));
                    default:   bresp  <= `AXI_SLVERR;
                endcase
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read path: one-cycle answer after the address is taken.
    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `AXI_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= `AXI_OKAY;
            case (araddr)
                `REG_CTRL: rdata <= ctrl_r;
                `REG_VEL:  rdata <= {8'h00, vel_r};
                `REG_STAT: rdata <= {6'h00, mstep_r, 10'h000, ms1_s, ms0_s,
                                     1'b0, drive_on, standstill_reduce, serial_r};
                `REG_COIL: rdata <= {7'h00, coil_b, 7'h00, coil_a};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= `AXI_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    chk_single_edge: assert property (!gen_on && !ctrl_r[`B_DUAL] && step_prev_r && !step_s
        |=> target_r == $past(target_r)) else $error("Falling edge moved the counter.");
    chk_step_fwd: assert property (step_ev && !step_back
        |=> target_r == 10'($past(target_r) + $past(incr))) else $error("Forward step wrong.");
    chk_step_back: assert property (step_ev && step_back
        |=> target_r == 10'($past(target_r) - $past(incr))) else $error("Backward step wrong.");
    chk_pin_res: assert property (use_pins && {ms1_s, ms0_s} == 2'h0
        |-> shift_eff == `RES_PIN_00) else $error("Pin resolution decode wrong.");
    chk_gen_dir: assert property (gen_on && gen_step |-> step_back == vel_r[`VEL_SIGN])
        else $error("Generator direction ignores velocity sign.");
    chk_index_zero: assert property (index_pulse |-> mstep_r == 10'h000
        && $past(mstep_r) != 10'h000) else $error("Index pulse away from zero.");
    chk_drive_off: assert property (enn_s |=> !drive_on ##1 coil_a == 9'sh000)
        else $error("Drive not off with enable pin high.");
    chk_serial_on: assert property ($rose(serial_r) |-> $past(ser_st_r) == SER_BITS
        && $past(byte1_r)) else $error("Serial mode set without a frame.");
    chk_interp_unit: assert property (ctrl_r[`B_INTP] && $past(ctrl_r[`B_INTP])
        && mstep_r != $past(mstep_r) |-> 10'(mstep_r - $past(mstep_r)) inside {10'h001, 10'h3FF})
        else $error("Interpolator jumped more than one microstep.");
endmodule : step_dir_microstep_sequencer
`default_nettype wire

// >>> dv/motion_host.sv
// Motion controller model: drives step, direction and the serial line.
`timescale 1ns/1ps
`default_nettype none
module motion_host (
    // Clock.
    input  wire logic aclk,
    // Pins toward the sequencer.
    output var logic  step_pin,
    output var logic  dir_pin,
    output var logic  ser_line
);
    // Idle levels: step low, serial line high.
    initial begin
        step_pin = 1'b0;
        dir_pin  = 1'b0;
        ser_line = 1'b1;
    end
    // One step pulse; direction is settled before and held past both edges.
    task automatic pulse(input logic d);
        dir_pin <= d;
        repeat (8) @(posedge aclk);
        step_pin <= 1'b1;
        repeat (12) @(posedge aclk);
        step_pin <= 1'b0;
        repeat (12) @(posedge aclk);
    endtask : pulse
    // One byte with start and stop bit, 32 clocks a bit, low bit first.
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            ser_line <= f[i];
            repeat (32) @(posedge aclk);
        end
    endtask : send_byte
    // Write-only frame; replies are never read, so no checksum is checked.
    task automatic frame(input logic [1:0] adr);
        send_byte(8'h05);
        send_byte({6'h00, adr});
    endtask : frame
endmodule : motion_host
`default_nettype wire

// >>> dv/test_step_dir_microstep_sequencer.sv
// Self-checking bench for the microstep sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.svh"
module test_step_dir_microstep_sequencer;
    import seq_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic step_pin, dir_pin, driver_enable_n, powerdown_serial_pin;
    logic resolution_select_0, resolution_select_1;
    logic drive_on, standstill_reduce, index_pulse, serial_active;
    coil_t coil_a, coil_b;
    mstep_t p0, p1;
    int err_count, check_count, cyc, idx_n, n0;
    int sz[4] = '{32, 8, 4, 16};

    step_dir_microstep_sequencer #(.STILL_CYC(200)) dut_u (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .step_pin, .dir_pin, .driver_enable_n,
        .powerdown_serial_pin, .resolution_select_0, .resolution_select_1,
        .coil_a, .coil_b, .drive_on, .standstill_reduce, .index_pulse, .serial_active);
    motion_host host_u (.aclk, .step_pin, .dir_pin, .ser_line(powerdown_serial_pin));

    // Clock, cycle limit and index pulse counter.
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (index_pulse === 1'b1) idx_n <= idx_n + 1;
        if (cyc == 30000) begin
            err_count++;
            final_report();
        end
    end
    // Counts one comparison and reports a mismatch.
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    // AXI4-Lite write; each channel released at the edge it is taken.
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    // AXI4-Lite read.
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask : rd
    // Step and read back the output position.
    task automatic step_pos(input logic dr, output mstep_t p);
        host_u.pulse(dr);
        rd(`REG_STAT);
        p = d[25:16];
    endtask : step_pos
    // Reset values, refusals and the enable pin.
    task automatic t_regs();
        rd(`REG_CTRL);
        chk(d === `CTRL_RST && r === `AXI_OKAY, "ctrl reset");
        rd(12'h010);
        chk(r === `AXI_SLVERR, "unmapped read");
        wr(`REG_STAT, 32'h0000_0000);
        chk(r === `AXI_SLVERR, "ro write");
        repeat (8) @(posedge aclk);
        chk(drive_on === 1'b0 && coil_a === 9'h000, "drive off");
        driver_enable_n <= 1'b0;
        repeat (8) @(posedge aclk);
        chk(drive_on === 1'b1, "drive on");
    endtask : t_regs
    // Direction, wrap, index, pin resolutions and dual edges.
    task automatic t_steps();
        wr(`REG_CTRL, 32'h0000_0000);
        step_pos(1'b1, p0);
        chk(p0 === 10'h3E0, "backward wrap");
        n0 = idx_n;
        step_pos(1'b0, p0);
        chk(p0 === 10'h000 && idx_n == n0 + 1, "index");
        rd(`REG_COIL);
        chk(d === 32'h00FF_0000 && coil_b === 9'h0FF, "coil at zero");
        for (int i = 0; i < 4; i++) begin
            {resolution_select_1, resolution_select_0} <= 2'(i);
            step_pos(1'b0, p0);
            step_pos(1'b0, p1);
            chk(p1 - p0 === 10'(sz[i]), "pin resolution");
        end
        wr(`REG_CTRL, 32'h0000_0001);
        step_pos(1'b0, p0);
        chk(p0 - p1 === 10'd32, "dual edge");
        {resolution_select_1, resolution_select_0} <= 2'b00;
    endtask : t_steps
    // Internal generator backward, then back to the step pin.
    task automatic t_vel();
        wr(`REG_CTRL, 32'h0000_0000);
        step_pos(1'b0, p0);
        wr(`REG_VEL, 32'h00F0_0000);
        repeat (100) @(posedge aclk);
        wr(`REG_VEL, 32'h0000_0000);
        step_pos(1'b0, p1);
        chk(10'(p0 - p1 + 10'd32) inside {[10'd1:10'd511]}, "velocity");
        step_pos(1'b0, p0);
        chk(p0 - p1 === 10'd32, "pins again");
    endtask : t_vel
    // Serial detection by address, then register-held standstill reduction.
    task automatic t_serial();
        host_u.frame(2'b01);
        chk(serial_active === 1'b0, "wrong address");
        host_u.frame(2'b00);
        repeat (4) @(posedge aclk);
        chk(serial_active === 1'b1, "serial on");
        wr(`REG_CTRL, 32'h0000_080E);
        step_pos(1'b0, p0);
        step_pos(1'b0, p1);
        chk(p1 - p0 === 10'h100, "register resolution");
        wr(`REG_CTRL, 32'h0000_081E);
        step_pos(1'b0, p0);
        chk(10'(p0 - p1) inside {[10'd1:10'd16]}, "interpolated");
        repeat (260) @(posedge aclk);
        chk(standstill_reduce === 1'b1, "reduce");
    endtask : t_serial
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report
    // Reset, then the scenarios in order.
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = {24'h0000_00, 32'h0000_0000, 4'hF};
        {driver_enable_n, resolution_select_0, resolution_select_1} = 3'b100;
        {err_count, check_count, cyc, idx_n} = {32'd0, 32'd0, 32'd0, 32'd0};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_steps();
        t_vel();
        t_serial();
        final_report();
    end
endmodule : test_step_dir_microstep_sequencer
`default_nettype wire
